// ---- verilog/cmbc_top.sv ----
// control of eight transmit/receive message buffers
`timescale 1ns/1ps
`include "cmbc_defines.svh"
module cmbc_top (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            addr,
	input  wire logic [15:0]           wdata,
	input  wire logic                  wr_stb,
	input  wire logic                  rd_stb,
	output logic      [15:0]           rdata,
	input  wire cmbc_pkg::cmbc_tx_evt_t tx_evt,
	input  wire cmbc_pkg::cmbc_rx_evt_t rx_evt,
	input  wire logic                  rx_we,
	input  wire logic [2:0]            rx_word,
	input  wire logic [15:0]           rx_wdata,
	output logic                       tx_pending,
	output logic      [2:0]            tx_buf,
	output logic                       tx_abort
);
	// ==========================================================
	// state
	cmbc_pkg::cmbc_ctrl_t ctrl_q [0:7]; // per buffer control
	logic [7:0]           full_q;       // receive full flags
	logic [2:0]           sel_q;        // buffer offered to link
	logic                 sel_vld_q;    // a request is pending
	logic [15:0]          rd_reg_q;     // register read data
	logic                 rd_ram_q;     // read came from RAM
	logic [7:0]           abort_req_q;  // abort asked per buffer
	logic [15:0]          ram_rdata;    // RAM read data
	logic                 ctrl_wr;      // write hits a control word
	logic [1:0]           ctrl_pair;    // which control word
	logic                 ram_hit_w;    // write targets RAM
	logic [2:0]           best_idx;     // arbitration winner
	logic                 best_vld;     // any pending
	logic [15:0]          ram_mask;     // mask for stored word
	logic                 ram_we;       // RAM write enable
	logic [5:0]           ram_waddr;    // RAM write address
	logic [15:0]          ram_wdata;    // RAM write data

	// ==========================================================
	// decode
	assign ctrl_wr   = wr_stb && (addr[7:2] == 6'(`CMBC_ADDR_CTRL_BASE >> 2));
	assign ctrl_pair = addr[1:0];
	assign ram_hit_w = wr_stb && addr[7];

	// ==========================================================
	// per buffer control, one generate entry per buffer
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_buf
			logic [7:0] wbyte; // byte for this buffer
			logic       hit;   // this buffer's control word written
			assign hit   = ctrl_wr && (ctrl_pair == 2'(gi / 2));
			assign wbyte = (gi % 2 == 1) ? wdata[15:8] : wdata[7:0];

			// software fields and request handling
			always_ff @(posedge clk) begin
				if (rst) begin
					ctrl_q[gi]      <= `CMBC_CTRL_RESET;
					abort_req_q[gi] <= 1'b0;
				end else begin
					if (hit) begin
						ctrl_q[gi].dir    <= wbyte[`CMBC_BIT_DIR];
						ctrl_q[gi].rtr_en <= wbyte[`CMBC_BIT_RTREN];
						ctrl_q[gi].prio   <= wbyte[1:0];
					end
					// link outcomes for the buffer in flight
					if (sel_vld_q && sel_q == 3'(gi)) begin
						if (tx_evt.arb_lost) begin
							ctrl_q[gi].arb_lost <= 1'b1;
						end
						if (tx_evt.bus_err) begin
							ctrl_q[gi].tx_err <= 1'b1;
						end
						if (tx_evt.aborted) begin
							ctrl_q[gi].aborted <= 1'b1;
							ctrl_q[gi].req     <= 1'b0;
							abort_req_q[gi]    <= 1'b0;
						end
						if (tx_evt.done) begin
							ctrl_q[gi].req     <= 1'b0;
							ctrl_q[gi].aborted <= 1'b0;
							abort_req_q[gi]    <= 1'b0;
						end
					end
					// software request or clear
					if (hit && wbyte[`CMBC_BIT_REQ] && !ctrl_q[gi].req) begin
						ctrl_q[gi].req      <= 1'b1;
						ctrl_q[gi].aborted  <= 1'b0;
						ctrl_q[gi].arb_lost <= 1'b0;
						ctrl_q[gi].tx_err   <= 1'b0;
						abort_req_q[gi]     <= 1'b0;
					end else if (hit && !wbyte[`CMBC_BIT_REQ] && ctrl_q[gi].req) begin
						abort_req_q[gi] <= 1'b1;
					end
					// remote frame auto reply
					if (rx_evt.valid && rx_evt.remote && rx_evt.buf_idx == 3'(gi)
						&& ctrl_q[gi].rtr_en && ctrl_q[gi].dir) begin
						ctrl_q[gi].req      <= 1'b1;
						ctrl_q[gi].aborted  <= 1'b0;
						ctrl_q[gi].arb_lost <= 1'b0;
						ctrl_q[gi].tx_err   <= 1'b0;
					end
				end
			end

			// receive full flag, set wins over clear
			always_ff @(posedge clk) begin
				if (rst) begin
					full_q[gi] <= 1'b0;
				end else if (rx_evt.valid && !rx_evt.remote && rx_evt.buf_idx == 3'(gi)
					&& !ctrl_q[gi].dir) begin
					full_q[gi] <= 1'b1;
				end else if (wr_stb && addr == `CMBC_ADDR_RXFULL_LO && !wdata[gi]) begin
					full_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// priority pick: highest field, lowest index on a tie
	always_comb begin
		best_idx = 3'h0;
		best_vld = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (ctrl_q[i].req && ctrl_q[i].dir) begin
				if (!best_vld || ctrl_q[i].prio >= ctrl_q[best_idx].prio) begin
					best_idx = 3'(i);
					best_vld = 1'b1;
				end
			end
		end
	end

	// offered buffer held while in flight
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q     <= 3'h0;
			sel_vld_q <= 1'b0;
		end else if (tx_evt.done || tx_evt.aborted || tx_evt.arb_lost) begin
			// buffer leaves flight; its request bit is still stale this cycle
			sel_vld_q <= 1'b0;
		end else if (!sel_vld_q) begin
			sel_q     <= best_idx;
			sel_vld_q <= best_vld;
		end
	end

	// ==========================================================
	// link outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_pending <= 1'b0;
			tx_buf     <= 3'h0;
			tx_abort   <= 1'b0;
		end else begin
			tx_pending <= sel_vld_q;
			tx_buf     <= sel_q;
			tx_abort   <= sel_vld_q && abort_req_q[sel_q];
		end
	end

	// ==========================================================
	// message RAM write: receive path wins over software
	always_comb begin
		unique case (rx_we ? rx_word : addr[2:0])
			3'h0:              ram_mask = `CMBC_MASK_SID_WORD;
			3'h1:              ram_mask = `CMBC_MASK_EID_WORD;
			3'h2:              ram_mask = `CMBC_MASK_DLC_WORD;
			`CMBC_WORD_STAT:   ram_mask = `CMBC_MASK_STAT_WORD;
			default:           ram_mask = 16'hFFFF;
		endcase
		ram_we    = rx_we || ram_hit_w;
		ram_waddr = rx_we ? {rx_evt.buf_idx, rx_word} : addr[5:0];
		ram_wdata = (rx_we ? rx_wdata : wdata) & ram_mask;
		if (rx_we && rx_word == `CMBC_WORD_STAT) begin
			ram_wdata = {3'h0, rx_evt.filt, 8'h00};
		end
	end

	cmbc_msg_ram u_ram (
		.clk   (clk),
		.we    (ram_we),
		.waddr (ram_waddr),
		.wdata (ram_wdata),
		.raddr (addr[5:0]),
		.rdata (ram_rdata)
	);

	// ==========================================================
	// register read, one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_reg_q <= 16'h0000;
			rd_ram_q <= 1'b0;
		end else if (rd_stb) begin
			rd_ram_q <= addr[7];
			if (addr[7:2] == 6'(`CMBC_ADDR_CTRL_BASE >> 2)) begin
				rd_reg_q <= {ctrl_q[{addr[1:0], 1'b1}], ctrl_q[{addr[1:0], 1'b0}]};
			end else if (addr == `CMBC_ADDR_RXFULL_LO) begin
				rd_reg_q <= {8'h00, full_q};
			end else if (addr == `CMBC_ADDR_TXSEL) begin
				rd_reg_q <= {12'h000, sel_vld_q, sel_q};
			end else begin
				rd_reg_q <= 16'h0000;
			end
		end
	end

	assign rdata = rd_ram_q ? ram_rdata : rd_reg_q;
endmodule

// ---- verilog/cmbc_defines.svh ----
// constants for the message buffer control block
// Overview of operation
// - direction bit 1 means transmit buffer
// - upper byte controls odd buffer, same layout
// - send request set by software, hardware clears
// - clearing pending request asks for abort
// - aborted flag set on abort only
// - lost arbitration flag set by link
// - bus error flag set by link
// - setting request clears all three flags
// - remote frame sets request when enabled
// - two-bit priority, 11 highest
// - standard id bits 12-2, 15-13 zero
// - bit 1 of word0 is SRR
// - bit 0 of word0 selects extended format
// - extended id split over words 1 and 2
// - bit 9 of word2 is RTR
// - length code bits 3-0, bits 7-5 zero
// - eight data bytes, odd byte upper half
// - buffer words live in message RAM
// - filter number stored in status word
// - full flag set on store, software clears
`ifndef CMBC_DEFINES_SVH
`define CMBC_DEFINES_SVH

// ==========================================================
// register map (word addresses on the plain port)
`define CMBC_ADDR_CTRL_BASE   8'h00
`define CMBC_ADDR_RXFULL_LO   8'h04
`define CMBC_ADDR_RXFULL_HI   8'h05
`define CMBC_ADDR_TXSEL       8'h06
`define CMBC_ADDR_RAM_BASE    8'h80
`define CMBC_RAM_WORDS_PER_BUF 3'h7

// ==========================================================
// control byte fields
`define CMBC_BIT_DIR          7
`define CMBC_BIT_ABORTED      6
`define CMBC_BIT_ARBLOST      5
`define CMBC_BIT_TXERR        4
`define CMBC_BIT_REQ          3
`define CMBC_BIT_RTREN        2
`define CMBC_CTRL_RESET       8'h00

// ==========================================================
// message word masks
`define CMBC_MASK_SID_WORD    16'h1FFF
`define CMBC_MASK_EID_WORD    16'h0FFF
`define CMBC_MASK_DLC_WORD    16'hFF1F
`define CMBC_MASK_STAT_WORD   16'h1F00
`define CMBC_WORD_STAT        3'h7

`endif

// ---- verilog/cmbc_pkg.sv ----
// types for the message buffer control block
package cmbc_pkg;
	// per buffer control byte
	typedef struct packed {
		logic       dir;
		logic       aborted;
		logic       arb_lost;
		logic       tx_err;
		logic       req;
		logic       rtr_en;
		logic [1:0] prio;
	} cmbc_ctrl_t;
	// link status event for the buffer in flight
	typedef struct packed {
		logic       done;
		logic       aborted;
		logic       arb_lost;
		logic       bus_err;
	} cmbc_tx_evt_t;
	// received frame store request
	typedef struct packed {
		logic       valid;
		logic [2:0] buf_idx;
		logic [4:0] filt;
		logic       remote;
	} cmbc_rx_evt_t;
endpackage

// ---- verilog/cmbc_msg_ram.sv ----
// message buffer RAM: 8 buffers by 8 words of 16 bits
`timescale 1ns/1ps
module cmbc_msg_ram (
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic [5:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [5:0]  raddr,
	output logic      [15:0] rdata
);
	logic [15:0] mem [0:63]; // buffer words

	// write port and registered read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ---- sim/cmbc_properties.sv ----
// port checker for the message buffer control block
`timescale 1ns/1ps
module cmbc_properties (
	input	wire logic			clk,
	input	wire logic			rst,
	input	wire logic [7:0]		addr,
	input	wire logic [15:0]		wdata,
	input	wire logic			wr_stb,
	input	wire logic			rd_stb,
	input	wire logic [15:0]		rdata,
	input	wire cmbc_pkg::cmbc_rx_evt_t	rx_evt,
	input	wire logic			tx_pending,
	input	wire logic [2:0]		tx_buf,
	input	wire logic			tx_abort
);
	// ==========
	// one clock domain, reset masks all
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_SID_ZERO: assert property (rd_stb && addr[7] && addr[2:0] == 3'h0 |=> rdata[15:13] == 3'h0)
		else $error("id word top bits set");
	AST_EID_ZERO: assert property (rd_stb && addr[7] && addr[2:0] == 3'h1 |=> rdata[15:12] == 4'h0)
		else $error("ext id word top bits set");
	AST_DLC_ZERO: assert property (rd_stb && addr[7] && addr[2:0] == 3'h2 |=> rdata[7:5] == 3'h0)
		else $error("length word gap bits set");
	AST_STAT_ZERO: assert property (rd_stb && addr[7] && addr[2:0] == 3'h7 |=> (rdata & 16'hE0FF) == 16'h0000)
		else $error("status word spare bits set");
	AST_REQ_EVEN: assert property (wr_stb && addr == 8'h00 && wdata == 16'h008B && !tx_pending
		|-> ##[1:4] tx_pending && tx_buf == 3'h0)
		else $error("even buffer not offered");
	AST_REQ_ODD: assert property (wr_stb && addr == 8'h00 && wdata == 16'h8B00 && !tx_pending
		|-> ##[1:4] tx_pending && tx_buf == 3'h1)
		else $error("odd buffer not offered");
	AST_ABORT: assert property (tx_pending && tx_buf == 3'h0 && wr_stb && addr == 8'h00 && wdata == 16'h0083
		|-> ##[1:3] tx_abort)
		else $error("abort not passed on");
	AST_REMOTE: assert property (rx_evt.valid && rx_evt.remote && rx_evt.buf_idx == 3'h4 && !tx_pending
		|-> ##[1:4] tx_pending)
		else $error("remote frame gave no reply");
	AST_FLAG_CLR: assert property (wr_stb && addr == 8'h00 && wdata[3] ##1 rd_stb && addr == 8'h00
		|=> rdata[6:4] == 3'h0)
		else $error("flags kept after request");
endmodule
bind cmbc_top cmbc_properties cmbc_properties_inst (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb,
	.rdata, .rx_evt, .tx_pending, .tx_buf, .tx_abort);

// ---- sim/cmbc_link_model.sv ----
// bus side model answering offered buffers
`timescale 1ns/1ps
module cmbc_link_model (
	input	wire logic			clk,
	input	wire logic			rst,
	input	wire logic [1:0]		mode,
	input	wire logic			tx_pending,
	input	wire logic			tx_abort,
	output	cmbc_pkg::cmbc_tx_evt_t		tx_evt
);
	logic [3:0]	cnt_q;	// cycles since offer
	// ==========
	// frame time counter
	always_ff @(posedge clk) begin
		if (rst || !tx_pending || tx_evt != 4'h0) cnt_q <= 4'h0;
		else cnt_q <= cnt_q + 4'h1;
	end
	// outcome pulse, mode 0 done, 1 lost, 2 error, 3 stall
	always_ff @(posedge clk) begin
		if (!rst && tx_pending && cnt_q == 4'h6) begin
			tx_evt <= '{done: !tx_abort && mode == 2'h0, aborted: tx_abort,
				arb_lost: !tx_abort && mode == 2'h1, bus_err: !tx_abort && mode == 2'h2};
		end else begin
			tx_evt <= 4'h0;
		end
	end
endmodule

// ---- sim/tb_top.sv ----
// testbench for the message buffer control block
`timescale 1ns/1ps
module tb_top;
	logic				clk = 1'b0;
	logic				rst = 1'b1;
	logic [7:0]			addr = 8'h00;
	logic [15:0]			wdata = 16'h0000;
	logic				wr_stb = 1'b0;
	logic				rd_stb = 1'b0;
	logic [15:0]			rdata;
	cmbc_pkg::cmbc_tx_evt_t		tx_evt;
	cmbc_pkg::cmbc_rx_evt_t		rx_evt = 10'h000;
	logic				rx_we = 1'b0;
	logic [2:0]			rx_word = 3'h0;
	logic [15:0]			rx_wdata = 16'h0000;
	logic				tx_pending;
	logic [2:0]			tx_buf;
	logic				tx_abort;
	logic [1:0]			mode = 2'h0;	// link outcome
	int				bad_count = 0;
	int				num_checks = 0;
	always #25 clk = ~clk;
	cmbc_top cmbc_top_inst (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .tx_evt, .rx_evt,
		.rx_we, .rx_word, .rx_wdata, .tx_pending, .tx_buf, .tx_abort);
	cmbc_link_model cmbc_link_model_inst (.clk, .rst, .mode, .tx_pending, .tx_abort, .tx_evt);
	// ==========
	// bus cycles and checks
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(posedge clk);
		cmp(rdata & m, e);
	endtask
	task automatic wt(input logic p);
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			if (tx_pending === p) return;
		end
		bad_count++;
		$display("[ERR] %0t wait timeout", $time);
		summarize();
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reg;
		for (logic [7:0] a = 8'h00; a < 8'h06; a++) rd(a, 16'hFFFF, 16'h0000);
		wr(8'h10, 16'hFFFF);
		rd(8'h10, 16'hFFFF, 16'h0000);
		wr(8'h88, 16'hFFFF);
		rd(8'h88, 16'hFFFF, 16'h1FFF);
		wr(8'h89, 16'hFFFF);
		rd(8'h89, 16'hFFFF, 16'h0FFF);
		wr(8'h8A, 16'hFEEF);
		rd(8'h8A, 16'hFFFF, 16'hFE0F);
	endtask
	task automatic t_tx;
		wr(8'h00, 16'h008B);
		wt(1'b1);
		cmp({13'h0000, tx_buf}, 16'h0000);
		wt(1'b0);
		rd(8'h00, 16'hFFFF, 16'h0083);
		wr(8'h00, 16'h8B00);
		wt(1'b1);
		cmp({13'h0000, tx_buf}, 16'h0001);
		wt(1'b0);
		rd(8'h00, 16'hFFFF, 16'h8300);
	endtask
	task automatic t_flags;
		mode <= 2'h1;
		wr(8'h00, 16'h008B);
		wt(1'b1);
		repeat (10) @(posedge clk);
		rd(8'h00, 16'h0020, 16'h0020);
		mode <= 2'h2;
		repeat (10) @(posedge clk);
		rd(8'h00, 16'h0010, 16'h0010);
		wr(8'h00, 16'h0083);
		wt(1'b0);
		rd(8'h00, 16'h0048, 16'h0040);
		mode <= 2'h0;
		wr(8'h00, 16'h008B);
		rd(8'h00, 16'h0070, 16'h0000);
		wt(1'b0);
	endtask
	task automatic t_prio;
		wr(8'h01, 16'h8A89);
		wt(1'b1);
		cmp({13'h0000, tx_buf}, 16'h0003);
		wt(1'b0);
		wt(1'b1);
		cmp({13'h0000, tx_buf}, 16'h0002);
		wt(1'b0);
		rd(8'h01, 16'hFFFF, 16'h8281);
	endtask
	task automatic t_rx;
		wr(8'h02, 16'h0084);
		rx_evt <= {1'b1, 3'h4, 5'h00, 1'b1};
		@(posedge clk);
		rx_evt <= 10'h000;
		wt(1'b1);
		cmp({13'h0000, tx_buf}, 16'h0004);
		wt(1'b0);
		rx_evt <= {1'b0, 3'h5, 5'h15, 1'b0};
		rx_we <= 1'b1;
		rx_word <= 3'h3;
		rx_wdata <= 16'h1234;
		@(posedge clk);
		rx_word <= 3'h7;
		rx_evt <= {1'b1, 3'h5, 5'h15, 1'b0};
		@(posedge clk);
		rx_we <= 1'b0;
		rx_evt <= 10'h000;
		rd(8'hAB, 16'hFFFF, 16'h1234);
		rd(8'hAF, 16'hFFFF, 16'h1500);
		rd(8'h04, 16'h0020, 16'h0020);
		wr(8'h04, 16'h0000);
		rd(8'h04, 16'h0020, 16'h0000);
		wr(8'h03, 16'h000C);
		repeat (8) @(posedge clk);
		cmp({15'h0000, tx_pending}, 16'h0000);
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reg();
		$display("reg test done");
		t_tx();
		$display("tx test done");
		t_flags();
		$display("flag test done");
		t_prio();
		$display("prio test done");
		t_rx();
		$display("rx test done");
		summarize();
	end
endmodule
